/* File: include/pulse_train_defines.svh */
/*
 * Constants of the pulse train engine: register offsets, field positions, reset values.
 * Assumes inclusion by bare name from package and design files.
 */
`ifndef PULSE_TRAIN_DEFINES_SVH
`define PULSE_TRAIN_DEFINES_SVH

`define PT_COUNT        16
`define PT_IDX_W        4
`define PT_ADDR_W       8
// Per-generator register block: base = index * 16
`define PT_REG_CFG      8'h00
`define PT_REG_PAT      8'h04
`define PT_REG_LOOP     8'h08
`define PT_REG_TRIG     8'h0C
// Global registers in block 15, which takes the place of generator 15's block
`define PT_REG_START    8'h00
`define PT_REG_STOP     8'h04
`define PT_REG_ENABLE   8'h08
`define PT_REG_PINS     8'h0C
`define PT_GLOBAL_SEL   4'hF
// Configuration field layout
`define PT_CFG_MODE_BIT 0
`define PT_CFG_LEN_LSB  8
`define PT_CFG_LEN_W    5
`define PT_CFG_DIV_LSB  16
`define PT_CFG_DIV_W    4
`define PT_CFG_RST      32'h0000_0000
`define PT_LEN_MIN      5'h01
`define PT_DIV_MAX      4'hE

`endif

/* File: include/pulse_train_pkg.sv */
/*
 * Types of the pulse train engine.
 * Assumes pulse_train_defines.svh is available on the include path.
 */
`include "pulse_train_defines.svh"

package pulse_train_pkg;

    typedef enum logic [1:0] {
        RUN_IDLE,
        RUN_ACTIVE
    } run_state_t;

    typedef struct packed {
        logic                      square;
        logic [`PT_CFG_LEN_W-1:0]  len_m1;
        logic [`PT_CFG_DIV_W-1:0]  div_exp;
        logic [31:0]               pattern;
        logic [15:0]               loops;
        logic [`PT_COUNT-1:0]      restart_sel;
    } gen_cfg_t;

endpackage

/* File: include/pt_gen_if.sv */
/*
 * Carrier between the engine top and one generator.
 * Assumes one clock, shared by both ends.
 */
`timescale 1ns/1ps
`include "pulse_train_defines.svh"

interface pt_gen_if;
    pulse_train_pkg::gen_cfg_t cfg;
    logic                      start;
    logic                      stop;
    logic                      tick;
    logic                      running;
    logic                      done;
    logic                      out;

    modport ctrl (output cfg, output start, output stop, output tick,
                  input running, input done, input out);
    modport gen  (input cfg, input start, input stop, input tick,
                  output running, output done, output out);
endinterface

/* File: hdl/pt_generator.sv */
/*
 * One pulse train generator: square wave or pattern shifter with loop count.
 * Assumes tick is a one-cycle pulse at its divided bit rate, aligned with start.
 */
`timescale 1ns/1ps
`include "pulse_train_defines.svh"

module pt_generator (
    // Clock and reset
    input  wire logic REF_CLK,
    input  wire logic RESET,
    // Link to engine
    pt_gen_if.gen     g
);
    pulse_train_pkg::run_state_t state_ff, nxt_state;
    logic [4:0]  bit_ff, nxt_bit;
    logic [15:0] loop_ff, nxt_loop;
    logic        out_ff, nxt_out;
    logic        done_ff, nxt_done;
    logic        tail_ff, nxt_tail;

    wire         last_bit   = g.cfg.square ? 1'b1 : (bit_ff == g.cfg.len_m1);
    wire         endless    = (g.cfg.loops == 16'h0000);
    wire         final_loop = !endless && (loop_ff <= 16'h0001);
    wire         cur_bit    = g.cfg.square ? ~out_ff : g.cfg.pattern[bit_ff];

    always_comb begin
        nxt_state = state_ff;
        nxt_bit   = bit_ff;
        nxt_loop  = loop_ff;
        nxt_out   = out_ff;
        nxt_done  = 1'b0;
        nxt_tail  = tail_ff;
        unique case (state_ff)
            pulse_train_pkg::RUN_IDLE: begin
                nxt_out  = 1'b0;
                nxt_tail = 1'b0;
                if (g.start) begin
                    nxt_state = pulse_train_pkg::RUN_ACTIVE;
                    nxt_bit   = 5'h00;
                    nxt_loop  = g.cfg.loops;
                end
            end
            pulse_train_pkg::RUN_ACTIVE: begin
                if (g.stop) begin
                    nxt_state = pulse_train_pkg::RUN_IDLE;
                    nxt_out   = 1'b0;
                    nxt_tail  = 1'b0;
                end else if (g.start) begin
                    nxt_bit  = 5'h00;
                    nxt_loop = g.cfg.loops;
                    nxt_tail = 1'b0;
                end else if (g.tick && tail_ff) begin
                    // Last bit has stood its full period
                    nxt_state = pulse_train_pkg::RUN_IDLE;
                    nxt_out   = 1'b0;
                    nxt_tail  = 1'b0;
                    nxt_done  = 1'b1;
                end else if (g.tick) begin
                    nxt_out = cur_bit;
                    if (!last_bit) begin
                        nxt_bit = bit_ff + 5'h01;
                    end else if (final_loop) begin
                        nxt_tail = 1'b1;
                    end else begin
                        nxt_bit = 5'h00;
                        if (!endless) begin
                            nxt_loop = loop_ff - 16'h0001;
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            state_ff <= pulse_train_pkg::RUN_IDLE;
            bit_ff   <= 5'h00;
            loop_ff  <= 16'h0000;
            out_ff   <= 1'b0;
            done_ff  <= 1'b0;
            tail_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            bit_ff   <= nxt_bit;
            loop_ff  <= nxt_loop;
            out_ff   <= nxt_out;
            done_ff  <= nxt_done;
            tail_ff  <= nxt_tail;
        end
    end

    assign g.running = (state_ff == pulse_train_pkg::RUN_ACTIVE);
    assign g.done    = done_ff;
    assign g.out     = out_ff;
endmodule // pt_generator

/* File: hdl/pulse_train_engine.sv */
/*
 * Pulse train engine: sixteen generators, registers for generators 0 to 14 only,
 * group start/stop, power-of-two dividers and loop-end restart chaining.
 * Assumes a synchronous register master with one-cycle strobes.
 */
// Overview of operation
// - Sixteen generators run independently, each on its own output.
// - Generators 0 to 14 each output a square wave or a 2 to 32 bit pattern.
// - A group started together shares one bit boundary.
// - Each generator keeps its own configuration and enable; generator 15's configuration stays at reset, as its block holds the globals.
// - A generator starts alone or with a set through one group write.
// - Bit rate is the clock divided by a power of two, at least two.
// - Single shot emits the pattern once and stops.
// - Repeat mode plays a set number of times, or forever until disabled.
// - End of a loop count restarts the generators it selects.
`timescale 1ns/1ps
`include "pulse_train_defines.svh"

module pulse_train_engine (
    // Clock and reset
    input  wire logic                  REF_CLK,
    input  wire logic                  RESET,
    // Register port
    input  wire logic [`PT_ADDR_W-1:0] ADDR,
    input  wire logic [31:0]           WDATA,
    input  wire logic                  WR,
    input  wire logic                  RD,
    output logic      [31:0]           RDATA,
    // Pulse outputs
    output logic      [`PT_COUNT-1:0]  PT_OUT
);
    // ****************************************
    // Register decode
    // ****************************************
    wire [3:0] blk   = ADDR[7:4];
    wire [7:0] sub   = {4'h0, ADDR[3:0]};
    wire       glob  = (blk == `PT_GLOBAL_SEL);
    wire       wr_g  = WR && glob;
    wire       start_wr = wr_g && (sub == `PT_REG_START);
    wire       stop_wr  = wr_g && (sub == `PT_REG_STOP);

    pulse_train_pkg::gen_cfg_t cfg_ff [`PT_COUNT];
    logic [`PT_COUNT-1:0] run_q;
    logic [`PT_COUNT-1:0] done_q;
    logic [`PT_COUNT-1:0] out_q;
    logic [`PT_COUNT-1:0] start_v;
    logic [`PT_COUNT-1:0] tick_v;
    logic [`PT_COUNT-1:0] restart_v;
    logic [14:0]          div_cnt_ff [`PT_COUNT];
    logic [`PT_COUNT-1:0] out_ff;
    logic [31:0]          rdata_ff;

    // ****************************************
    // Loop-end restart fan-out
    // ****************************************
    always_comb begin
        restart_v = '0;
        for (int s = 0; s < `PT_COUNT; s++) begin
            if (done_q[s]) begin
                restart_v = restart_v | cfg_ff[s].restart_sel;
            end
        end
    end

    assign start_v = (start_wr ? WDATA[`PT_COUNT-1:0] : '0) | restart_v;

    // ****************************************
    // Generators
    // ****************************************
    genvar i;
    generate
        for (i = 0; i < `PT_COUNT; i++) begin : gen_pt
            pt_gen_if link ();
            wire       sel     = WR && !glob && (blk == 4'(i));
            wire [3:0] dexp    = cfg_ff[i].div_exp;
            wire [14:0] dmax   = 15'((32'h2 << dexp) - 32'h1);
            wire       div_end = (div_cnt_ff[i] >= dmax);

            assign link.cfg   = cfg_ff[i];
            assign link.start = start_v[i];
            assign link.stop  = stop_wr && WDATA[i];
            assign link.tick  = div_end;
            assign run_q[i]   = link.running;
            assign done_q[i]  = link.done;
            assign out_q[i]   = link.out;

            always_ff @(posedge REF_CLK) begin
                if (RESET) begin
                    cfg_ff[i] <= '0;
                end else if (sel && sub == `PT_REG_CFG) begin
                    cfg_ff[i].square  <= WDATA[`PT_CFG_MODE_BIT];
                    cfg_ff[i].len_m1  <= (WDATA[12:8] < `PT_LEN_MIN) ? `PT_LEN_MIN
                                                                     : WDATA[12:8];
                    cfg_ff[i].div_exp <= (WDATA[19:16] > `PT_DIV_MAX) ? `PT_DIV_MAX
                                                                      : WDATA[19:16];
                end else if (sel && sub == `PT_REG_PAT) begin
                    cfg_ff[i].pattern <= WDATA;
                end else if (sel && sub == `PT_REG_LOOP) begin
                    cfg_ff[i].loops   <= WDATA[15:0];
                end else if (sel && sub == `PT_REG_TRIG) begin
                    cfg_ff[i].restart_sel <= WDATA[`PT_COUNT-1:0];
                end
            end

            // Divider restarts on start so a group shares its bit edges
            always_ff @(posedge REF_CLK) begin
                if (RESET) begin
                    div_cnt_ff[i] <= 15'h0000;
                end else if (start_v[i] || !run_q[i] || div_end) begin
                    div_cnt_ff[i] <= 15'h0000;
                end else begin
                    div_cnt_ff[i] <= div_cnt_ff[i] + 15'h0001;
                end
            end

            pt_generator u_gen (
                .REF_CLK (REF_CLK),
                .RESET   (RESET),
                .g       (link.gen)
            );
        end
    endgenerate

    // ****************************************
    // Read back and outputs
    // ****************************************
    wire [3:0] rblk = blk;
    wire [31:0] cfg_word = {12'h000, cfg_ff[rblk].div_exp, 3'h0, cfg_ff[rblk].len_m1,
                            7'h00, cfg_ff[rblk].square};
    wire [31:0] gen_rd =
        (sub == `PT_REG_CFG)  ? cfg_word :
        (sub == `PT_REG_PAT)  ? cfg_ff[rblk].pattern :
        (sub == `PT_REG_LOOP) ? {16'h0000, cfg_ff[rblk].loops} :
        (sub == `PT_REG_TRIG) ? {16'h0000, cfg_ff[rblk].restart_sel} : 32'h0000_0000;
    wire [31:0] glob_rd =
        (sub == `PT_REG_ENABLE) ? {16'h0000, run_q} :
        (sub == `PT_REG_PINS)   ? {16'h0000, out_ff} : 32'h0000_0000;
    wire [31:0] rd_mux = glob ? glob_rd : gen_rd;

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            rdata_ff <= 32'h0000_0000;
            out_ff   <= '0;
        end else begin
            rdata_ff <= RD ? rd_mux : 32'h0000_0000;
            out_ff   <= out_q & run_q;
        end
    end

    assign RDATA  = rdata_ff;
    assign PT_OUT = out_ff;
endmodule // pulse_train_engine

/* File: test/pt_engine_asserts.sv */
/* Port checker for the pulse train engine.
   Assumes it is bound onto pulse_train_engine and sees its ports only. */
`timescale 1ns/1ps
module pt_engine_asserts (
    // Clock and reset
    input wire logic        REF_CLK,
    input wire logic        RESET,
    // Register port and pins
    input wire logic [7:0]  ADDR,
    input wire logic [31:0] WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [31:0] RDATA,
    input wire logic [15:0] PT_OUT
);
    // ****************
    // Port relations
    // ****************
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RESET);

    a_rdata_idle_zero: assert property (
        !$past(RD) |-> RDATA == 32'h0) else $error("read data not idle");
    a_pins_reset_low: assert property (
        $fell(RESET) |-> PT_OUT == 16'h0) else $error("pins high after reset");
    a_pins_read_back: assert property (
        RD && ADDR == 8'hFC |=> RDATA == {16'h0, $past(PT_OUT)}) else $error("pin read wrong");
    a_stop_drives_low: assert property (
        WR && ADDR == 8'hF4 && WDATA[15:0] == 16'hFFFF |-> ##[1:3] PT_OUT == 16'h0)
        else $error("stop left pins high");
    a_bit_min_period: assert property (
        $rose(PT_OUT[0]) && !WR && !$past(WR) |=> PT_OUT[0]) else $error("bit shorter than two");
    a_pattern_kept: assert property (
        WR && ADDR == 8'h04 ##2 RD && ADDR == 8'h04 |=> RDATA == $past(WDATA, 3))
        else $error("pattern not kept");
    a_stop_clears_run: assert property (
        WR && ADDR == 8'hF4 && WDATA[15:0] == 16'hFFFF ##2 RD && ADDR == 8'hF8 |=> RDATA == 32'h0)
        else $error("enable not cleared");
    a_start_sets_run: assert property (
        WR && ADDR == 8'hF0 && WDATA[15:0] == 16'h0001 ##2 RD && ADDR == 8'hF8 |=> RDATA[0])
        else $error("start did not run");
endmodule // pt_engine_asserts

bind pulse_train_engine pt_engine_asserts chk_u (.REF_CLK, .RESET, .ADDR, .WDATA, .WR, .RD,
    .RDATA, .PT_OUT);

/* File: test/pt_pins_model.sv */
/* External load on the pulse pins: remembers which pins ever went high.
   Assumes one clock; clr empties the record. */
`timescale 1ns/1ps
module pt_pins_model (
    // Clock and clear
    input  wire logic        clk,
    input  wire logic        clr,
    // Pins
    input  wire logic [15:0] pins,
    output logic      [15:0] hi_seen
);
    always_ff @(posedge clk) begin
        hi_seen <= clr ? 16'h0000 : (hi_seen | pins);
    end
endmodule // pt_pins_model

/* File: test/tb_top.sv */
/* Self-checking bench for the pulse train engine.
   Assumes the checker is bound by its own file. */
`timescale 1ns/1ps
`include "pulse_train_defines.svh"
module tb_top;
    logic        REF_CLK, RESET, WR, RD;
    logic [7:0]  ADDR;
    logic [31:0] WDATA, RDATA, d;
    logic [15:0] PT_OUT, hi_seen;
    int          n_errors, samples_checked;

    pulse_train_engine dut_u (.REF_CLK, .RESET, .ADDR, .WDATA, .WR, .RD, .RDATA, .PT_OUT);
    pt_pins_model pins_u (.clk(REF_CLK), .clr(RESET), .pins(PT_OUT), .hi_seen(hi_seen));

    initial begin
        REF_CLK = 1'b0;
        forever #5 REF_CLK = ~REF_CLK;
    end
    // ****************
    // Shared tasks
    // ****************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task stop_test;
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        ADDR <= a;
        WDATA <= v;
        WR <= 1'b1;
        @(posedge REF_CLK);
        WR <= 1'b0;
        @(posedge REF_CLK);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge REF_CLK);
        RD <= 1'b0;
        #1 v = RDATA;
        @(posedge REF_CLK);
    endtask
    task automatic wait_rise(input int i);
        logic prev;
        #1 prev = PT_OUT[i];
        for (int k = 0; k < 300; k++) begin
            @(posedge REF_CLK);
            #1;
            if (prev === 1'b0 && PT_OUT[i] === 1'b1) return;
            prev = PT_OUT[i];
        end
        chk(32'h1, 32'h0);
        stop_test;
    endtask
    task automatic sample(input int i, input int gap, input logic exp);
        repeat (gap) @(posedge REF_CLK);
        #1 chk(PT_OUT[i], exp);
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_square;
        wr(8'h00, 32'h0000_0001);
        wr(8'h04, 32'hA5C3_0F96);
        rd(8'h04, d);
        chk(d, 32'hA5C3_0F96);
        wr(8'hF0, 32'h0000_0001);
        rd(8'hF8, d);
        chk(d[0], 32'h1);
        wait_rise(0);
        for (int j = 1; j <= 8; j++) sample(0, 1, (j % 4) < 2);
        @(posedge REF_CLK);
        wr(8'hF4, 32'h0000_FFFF);
        rd(8'hF8, d);
        chk(d, 32'h0);
        sample(0, 1, 1'b0);
    endtask
    task automatic t_loop;
        wr(8'h50, 32'h0000_0001);
        wr(8'h10, 32'h0001_0300);
        wr(8'h14, 32'h0000_000D);
        wr(8'h18, 32'h0000_0002);
        wr(8'h1C, 32'h0000_0020);
        wr(8'hF0, 32'h0000_0002);
        wait_rise(1);
        for (int j = 0; j < 8; j++) sample(1, (j == 0) ? 1 : 4, (4'hD >> (j % 4)) & 1);
        sample(1, 4, 1'b0);
        @(posedge REF_CLK);
        rd(8'hF8, d);
        chk(d & 32'h22, 32'h20);
        wr(8'hF4, 32'h0000_FFFF);
    endtask
    task automatic t_group;
        wr(8'h20, 32'h0002_0001);
        wr(8'h30, 32'h0002_0001);
        wr(8'hF0, 32'h0000_000C);
        wait_rise(2);
        for (int j = 1; j <= 24; j++) begin
            @(posedge REF_CLK);
            #1 chk(PT_OUT[4:2], ((j % 16) < 8) ? 3'h3 : 3'h0);
        end
        repeat (8) @(posedge REF_CLK);
        rd(8'hFC, d);
        chk(d, 32'h0000_000C);
        chk(hi_seen[4], 32'h0);
        wr(8'hF4, 32'h0000_FFFF);
    endtask

    initial begin
        RESET = 1'b1;
        WR = 1'b0;
        RD = 1'b0;
        ADDR = 8'h00;
        WDATA = 32'h0;
        n_errors = 0;
        samples_checked = 0;
        repeat (2) @(posedge REF_CLK);
        RESET <= 1'b0;
        @(posedge REF_CLK);
        rd(8'h10, d);
        chk(d, `PT_CFG_RST);
        #1 chk(PT_OUT, 32'h0);
        t_square;
        t_loop;
        t_group;
        stop_test;
    end
endmodule // tb_top
